// ---- verilog/spicsf_map.vh ----
`ifndef SPICSF_MAP_VH
`define SPICSF_MAP_VH
// Slave select mode encodings
`define SPICSF_NSM_3WIRE     2'h0
`define SPICSF_NSM_4WIRE_IN  2'h1
`define SPICSF_NSM_RESET     2'h1
// Bit positions inside the mode field
`define SPICSF_NSM_HI        1
`define SPICSF_NSM_LO        0
// Reset values and bit counter constants
`define SPICSF_BYTE_ZERO     8'h00
`define SPICSF_BITS_PER_BYTE 4'h8
`define SPICSF_CNT_ZERO      4'h0
`define SPICSF_CNT_ONE       4'h1
// Transmit FIFO shape
`define SPICSF_FIFO_DEPTH    16
`define SPICSF_FIFO_AW       4
`endif

// ---- verilog/spicsf_fifo.v ----
`timescale 1ns/10ps
// Synchronous FIFO with valid/ready on both sides
module spicsf_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             sys_clk,
    input  wire             rst_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage
    reg [AW-1:0]    wr_ptr;          // Write index
    reg [AW-1:0]    rd_ptr;          // Read index
    reg [AW:0]      count;           // Words held
    wire            push;
    wire            pop;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage write
    always @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and occupancy
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // spicsf_fifo

// ---- verilog/spicsf_shift.v ----
`timescale 1ns/10ps
`include "spicsf_map.vh"
// Byte shifter: loads a byte, moves one bit per bit strobe
module spicsf_shift #(
    parameter WIDTH = 8
) (
    input  wire             sys_clk,
    input  wire             rst_n,
    input  wire             load,
    input  wire [WIDTH-1:0] load_data,
    input  wire             bit_strobe,
    input  wire             bit_in,
    output wire             bit_out,
    output reg              busy,
    output reg              last_bit,
    output reg  [WIDTH-1:0] shift_reg
);
    reg [3:0] bits_left; // Bits still to move

    assign bit_out = shift_reg[WIDTH-1];

    // Shift sequence, last_bit pulses when the final bit enters
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= `SPICSF_BYTE_ZERO;
            bits_left <= `SPICSF_CNT_ZERO;
            busy      <= 1'b0;
            last_bit  <= 1'b0;
        end else begin
            last_bit <= 1'b0;
            if (load && !busy) begin
                shift_reg <= load_data;
                bits_left <= `SPICSF_BITS_PER_BYTE;
                busy      <= 1'b1;
            end else if (busy && bit_strobe) begin
                shift_reg <= {shift_reg[WIDTH-2:0], bit_in};
                bits_left <= bits_left - `SPICSF_CNT_ONE;
                if (bits_left == `SPICSF_CNT_ONE) begin
                    busy     <= 1'b0;
                    last_bit <= 1'b1;
                end
            end
        end
    end
endmodule // spicsf_shift

// ---- verilog/spicsf_flags.v ----
`timescale 1ns/10ps
`include "spicsf_map.vh"
module spicsf_flags #(
    parameter WIDTH = 8,
    parameter DEPTH = `SPICSF_FIFO_DEPTH,
    parameter AW    = `SPICSF_FIFO_AW
) (
    input  wire             sys_clk,
    input  wire             rst_n,
    input  wire             port_enable,
    input  wire             master_enable,
    input  wire [1:0]       slave_select_mode,
    input  wire             data_write,
    input  wire [WIDTH-1:0] data_in,
    output wire             data_ready,
    input  wire             rx_read,
    output reg  [WIDTH-1:0] rx_data,
    output reg              rx_full,
    input  wire             bit_strobe,
    input  wire             serial_in,
    output wire             serial_out,
    input  wire             slave_select_line_in,
    output reg              slave_select_line_out,
    output reg              slave_select_line_oe,
    input  wire             clear_write_collision,
    input  wire             clear_mode_fault,
    input  wire             clear_receive_overrun,
    output reg              write_collision_flag,
    output reg              mode_fault_flag,
    output reg              receive_overrun_flag,
    output reg              transmit_buffer_empty,
    output wire             port_irq
);
    wire             fifo_valid;  // Byte waiting for shifter
    wire [WIDTH-1:0] fifo_data;   // Head byte
    wire [WIDTH-1:0] load_word;   // Byte handed to the shifter
    wire             sh_busy;     // Transfer under way
    wire             sh_last;     // Final bit entered
    wire [WIDTH-1:0] sh_reg;      // Shifter contents
    wire             load;        // Shifter starts a byte
    wire             active;      // Port enabled
    wire             is_slave;    // Slave operation
    wire             sel_low;     // Select asserted
    wire             set_write_collision_flag;    // Collision event this cycle
    wire             set_mode_fault_flag;    // Mode fault event this cycle
    wire             set_ovr;     // Overrun event this cycle
    wire             accept;      // Write reaches the FIFO
    wire             rx_take;     // Finished byte goes to receive buffer
    wire             rx_blocked;  // Receive buffer holds unread data

    // Next values of the select pin
    reg              next_select_out;
    reg              next_select_oe;
    // Next values of the error flags
    reg              next_write_collision;
    reg              next_mode_fault;
    reg              next_receive_overrun;
    // Next value of the transmit buffer indication
    reg              next_buffer_empty;

    // Mode field asks the block to drive the select pin
    function spicsf_drives_select;
        input [1:0] mode;
        begin
            spicsf_drives_select = mode[`SPICSF_NSM_HI];
        end
    endfunction

    // Mode field in which a low select means a master collision
    function spicsf_fault_mode;
        input [1:0] mode;
        begin
            spicsf_fault_mode = (mode == `SPICSF_NSM_4WIRE_IN);
        end
    endfunction

    // Sticky flag update: an event wins over a clear in one cycle
    function spicsf_sticky;
        input cur;
        input set;
        input clr;
        begin
            if (set) begin
                spicsf_sticky = 1'b1;
            end else if (clr) begin
                spicsf_sticky = 1'b0;
            end else begin
                spicsf_sticky = cur;
            end
        end
    endfunction

    // Whole port follows the enable bit
    assign active     = port_enable;
    assign is_slave   = ~master_enable;
    assign sel_low    = ~slave_select_line_in;
    // A master starts when a byte waits; a slave starts once selected,
    // so it can receive even with nothing queued to send
    assign load       = active & ~sh_busy & (is_slave ? sel_low : fifo_valid);
    // Empty FIFO in slave operation shifts out zeros
    assign load_word  = fifo_valid ? fifo_data : {WIDTH{1'b0}};
    // Writes only land while no byte is on the wire
    assign accept     = data_write & active & ~sh_busy;
    assign set_write_collision_flag   = active & data_write & sh_busy;
    assign set_mode_fault_flag   = active & master_enable & sel_low
                      & spicsf_fault_mode(slave_select_mode);
    assign rx_blocked = rx_full & ~rx_read;
    assign set_ovr    = active & is_slave & sh_last & rx_blocked;
    assign rx_take    = sh_last & ~rx_blocked;
    // Interrupt request is the OR of the sticky flags
    assign port_irq   = write_collision_flag | mode_fault_flag | receive_overrun_flag;

    // Transmit FIFO in the data path
    spicsf_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (accept),
        .in_ready  (data_ready),
        .in_data   (data_in),
        .out_valid (fifo_valid),
        .out_ready (load),
        .out_data  (fifo_data)
    );

    // Shift engine
    spicsf_shift #(.WIDTH(WIDTH)) u_shift (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .load       (load),
        .load_data  (load_word),
        .bit_strobe (bit_strobe & active),
        .bit_in     (serial_in),
        .bit_out    (serial_out),
        .busy       (sh_busy),
        .last_bit   (sh_last),
        .shift_reg  (sh_reg)
    );

    // Select pin decode: released unless enabled and in a driving mode
    always @* begin
        next_select_out = 1'b0;
        next_select_oe  = 1'b0;
        if (!active) begin
            // Disabled port leaves the pin alone
            next_select_out = 1'b0;
            next_select_oe  = 1'b0;
        end else if (spicsf_drives_select(slave_select_mode)) begin
            // Single master: pin follows the low mode bit
            next_select_out = slave_select_mode[`SPICSF_NSM_LO];
            next_select_oe  = 1'b1;
        end else begin
            // Three-wire or four-wire input: never driven
            next_select_out = 1'b0;
            next_select_oe  = 1'b0;
        end
    end

    // Slave select pin direction and level, one cycle behind the field
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            slave_select_line_out <= 1'b0;
            slave_select_line_oe  <= 1'b0;
        end else begin
            slave_select_line_out <= next_select_out;
            slave_select_line_oe  <= next_select_oe;
        end
    end

    // Error flag decode, set takes precedence over clear
    always @* begin
        // Collision: write while a byte is on the wire
        next_write_collision = spicsf_sticky(write_collision_flag, set_write_collision_flag,
                                             clear_write_collision);
        // Mode fault: never cleared by hardware
        next_mode_fault      = spicsf_sticky(mode_fault_flag, set_mode_fault_flag,
                                             clear_mode_fault);
        // Overrun: slave byte finished over unread data
        next_receive_overrun = spicsf_sticky(receive_overrun_flag, set_ovr,
                                             clear_receive_overrun);
    end

    // Error flag registers
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            write_collision_flag <= 1'b0;
            mode_fault_flag      <= 1'b0;
            receive_overrun_flag <= 1'b0;
        end else begin
            write_collision_flag <= next_write_collision;
            mode_fault_flag      <= next_mode_fault;
            receive_overrun_flag <= next_receive_overrun;
        end
    end

    // Buffer empty decode: a landing write beats a same-cycle start
    always @* begin
        next_buffer_empty = transmit_buffer_empty;
        if (accept) begin
            // New byte queued
            next_buffer_empty = 1'b0;
        end else if (load) begin
            // Byte moved into the shifter
            next_buffer_empty = 1'b1;
        end
    end

    // Transmit buffer empty register, empty out of reset
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            transmit_buffer_empty <= 1'b1;
        end else begin
            transmit_buffer_empty <= next_buffer_empty;
        end
    end

    // Receive buffer, overrun keeps the unread byte
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_data <= `SPICSF_BYTE_ZERO;
            rx_full <= 1'b0;
        end else if (rx_take) begin
            // Finished byte lands in the free buffer
            rx_data <= sh_reg;
            rx_full <= 1'b1;
        end else if (rx_read) begin
            // Software took the byte
            rx_full <= 1'b0;
        end
    end
endmodule // spicsf_flags

// ---- verification/spicsf_chk.sv ----
`timescale 1ns/10ps
// Watches flag, select and interrupt outputs of the flag block
module spicsf_chk (
    input wire       sys_clk,
    input wire       rst_n,
    input wire       port_enable,
    input wire       master_enable,
    input wire [1:0] slave_select_mode,
    input wire       data_write,
    input wire       slave_select_line_in,
    input wire       slave_select_line_out,
    input wire       slave_select_line_oe,
    input wire       clear_write_collision,
    input wire       clear_mode_fault,
    input wire       clear_receive_overrun,
    input wire       write_collision_flag,
    input wire       mode_fault_flag,
    input wire       receive_overrun_flag,
    input wire       transmit_buffer_empty,
    input wire       port_irq
);
    // One clock domain, reset disables all
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_write_collision_flag_cause: assert property (
        !write_collision_flag && !data_write |=> !write_collision_flag)
        else $error("collision flag rose without a write");
    a_write_collision_flag_hold: assert property (
        write_collision_flag && !clear_write_collision |=> write_collision_flag)
        else $error("collision flag dropped without a clear");
    a_mode_fault_flag_set: assert property (
        port_enable && master_enable && slave_select_mode == 2'h1 && !slave_select_line_in
        |-> ##[1:2] mode_fault_flag)
        else $error("mode fault not flagged");
    a_mode_fault_flag_hold: assert property (
        mode_fault_flag && !clear_mode_fault |=> mode_fault_flag)
        else $error("mode fault dropped without a clear");
    a_ovr_hold: assert property (
        receive_overrun_flag && !clear_receive_overrun |=> receive_overrun_flag)
        else $error("overrun dropped without a clear");
    a_irq_or: assert property (
        port_irq == (write_collision_flag | mode_fault_flag | receive_overrun_flag))
        else $error("interrupt differs from flag OR");
    a_tbe_write: assert property (
        port_enable && data_write |=> !transmit_buffer_empty || write_collision_flag)
        else $error("buffer empty stayed high after write");
    a_sel_drive: assert property (
        port_enable && slave_select_mode[1] ##1 port_enable && $stable(slave_select_mode)
        |=> slave_select_line_oe && slave_select_line_out == $past(slave_select_mode[0]))
        else $error("select not driven from mode low bit");
    a_sel_input: assert property (
        port_enable && !slave_select_mode[1] ##1 port_enable && $stable(slave_select_mode)
        |=> !slave_select_line_oe)
        else $error("select driven in input mode");
endmodule // spicsf_chk

bind spicsf_flags spicsf_chk spicsf_chk_inst (.sys_clk, .rst_n, .port_enable, .master_enable,
    .slave_select_mode, .data_write, .slave_select_line_in, .slave_select_line_out,
    .slave_select_line_oe, .clear_write_collision, .clear_mode_fault, .clear_receive_overrun,
    .write_collision_flag, .mode_fault_flag, .receive_overrun_flag, .transmit_buffer_empty,
    .port_irq);

// ---- verification/spicsf_remote.sv ----
`timescale 1ns/10ps
// Remote SPI party: selects, strobes bits MSB first, captures serial_out
module spicsf_remote (
    input  wire sys_clk,
    input  wire serial_out,
    output reg  bit_strobe,
    output reg  serial_in,
    output reg  slave_select_line_in
);
    // Idle: deselected, no strobes
    initial begin
        bit_strobe = 1'b0;
        serial_in = 1'b0;
        slave_select_line_in = 1'b1;
    end
    // Select line level, low selects the block
    task sel(input logic v);
        slave_select_line_in <= v;
    endtask
    // One byte each way, one strobe per bit
    task send(input logic [7:0] b, output logic [7:0] got);
        int i;
        slave_select_line_in <= 1'b0;
        for (i = 7; i >= 0; i--) begin
            @(posedge sys_clk);
            bit_strobe <= 1'b1;
            serial_in <= b[i];
            @(posedge sys_clk);
            got[i] = serial_out;
            bit_strobe <= 1'b0;
        end
        @(posedge sys_clk);
        slave_select_line_in <= 1'b1;
        serial_in <= ~serial_in; // Released line does not hold its value
    endtask
endmodule // spicsf_remote

// ---- verification/spicsf_flags_test.sv ----
`timescale 1ns/10ps
// Self-checking bench for the flag block
module spicsf_flags_test;
    logic       sys_clk, rst_n, port_enable, master_enable, data_write, rx_read;
    logic       clear_write_collision, clear_mode_fault, clear_receive_overrun;
    logic [1:0] slave_select_mode;
    logic [7:0] data_in, got;
    wire        bit_strobe, serial_in, slave_select_line_in, data_ready, rx_full, serial_out;
    wire        slave_select_line_out, slave_select_line_oe, port_irq, transmit_buffer_empty;
    wire        write_collision_flag, mode_fault_flag, receive_overrun_flag;
    wire  [7:0] rx_data;
    int         err_total = 0;
    int         checks = 0;
    spicsf_flags spicsf_flags_inst (.sys_clk, .rst_n, .port_enable, .master_enable,
        .slave_select_mode, .data_write, .data_in, .data_ready, .rx_read, .rx_data, .rx_full,
        .bit_strobe, .serial_in, .serial_out, .slave_select_line_in, .slave_select_line_out,
        .slave_select_line_oe, .clear_write_collision, .clear_mode_fault,
        .clear_receive_overrun, .write_collision_flag, .mode_fault_flag,
        .receive_overrun_flag, .transmit_buffer_empty, .port_irq);
    spicsf_remote spicsf_remote_inst (.sys_clk, .serial_out, .bit_strobe, .serial_in,
        .slave_select_line_in);
    // Compare and count
    task chk(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Mode field sweep, select direction and level
    task t_modes;
        for (int m = 0; m < 4; m++) begin
            slave_select_mode <= m[1:0];
            tick(3);
            #1 chk({slave_select_line_oe, slave_select_line_out & m[1]}, m[1] * 3 & m[0] | m[1] * 2);
        end
        $display("done modes");
    endtask
    // Master byte, buffer empty pulse, write during transfer
    task t_tx;
        int n = 0;
        master_enable <= 1'b1;
        slave_select_mode <= 2'h2;
        data_in <= 8'hA5;
        data_write <= 1'b1;
        tick(1);
        data_write <= 1'b0;
        repeat (4) begin
            #1 n += !transmit_buffer_empty;
            tick(1);
        end
        chk(n != 0, 1);
        #1 chk({transmit_buffer_empty, data_ready}, 3);
        data_write <= 1'b1;
        tick(1);
        data_write <= 1'b0;
        tick(2);
        #1 chk({write_collision_flag, port_irq}, 3);
        spicsf_remote_inst.send(8'h00, got);
        chk(got, 8'hA5);
        #1 chk({rx_full, rx_data}, 9'h100);
        rx_read <= 1'b1;
        clear_write_collision <= 1'b1;
        tick(1);
        rx_read <= 1'b0;
        clear_write_collision <= 1'b0;
        tick(2);
        #1 chk(write_collision_flag, 0);
        $display("done transmit");
    endtask
    // Mode fault, clear while fault persists, then real clear
    task t_mode_fault_flag;
        slave_select_mode <= 2'h1;
        spicsf_remote_inst.sel(1'b0);
        tick(3);
        #1 chk({mode_fault_flag, port_irq}, 3);
        clear_mode_fault <= 1'b1;
        tick(1);
        clear_mode_fault <= 1'b0;
        tick(2);
        #1 chk(mode_fault_flag, 1);
        spicsf_remote_inst.sel(1'b1);
        master_enable <= 1'b0;
        tick(2);
        clear_mode_fault <= 1'b1;
        tick(1);
        clear_mode_fault <= 1'b0;
        tick(2);
        #1 chk(mode_fault_flag, 0);
        $display("done mode fault");
    endtask
    // Slave receive, then overrun keeps the old byte
    task t_rx;
        spicsf_remote_inst.send(8'h3C, got);
        tick(2);
        #1 chk({rx_full, rx_data}, 9'h13C);
        spicsf_remote_inst.send(8'hC3, got);
        tick(2);
        #1 chk({receive_overrun_flag, rx_data}, 9'h13C);
        rx_read <= 1'b1;
        clear_receive_overrun <= 1'b1;
        tick(1);
        rx_read <= 1'b0;
        clear_receive_overrun <= 1'b0;
        tick(2);
        #1 chk({receive_overrun_flag, rx_full}, 0);
        $display("done receive");
    endtask
    // Disabled port ignores writes and fault conditions
    task t_off;
        port_enable <= 1'b0;
        master_enable <= 1'b1;
        spicsf_remote_inst.sel(1'b0);
        data_write <= 1'b1;
        tick(1);
        data_write <= 1'b0;
        tick(3);
        #1 chk({transmit_buffer_empty, write_collision_flag, mode_fault_flag}, 4);
        $display("done disable");
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // Watchdog, far beyond the roughly 105 cycles the tests need
    initial begin
        #200000;
        err_total++;
        tally_and_finish;
    end
    // Main sequence
    initial begin
        {rst_n, port_enable, master_enable, data_write, rx_read} = 5'h00;
        {clear_write_collision, clear_mode_fault, clear_receive_overrun} = 3'h0;
        slave_select_mode = 2'h1;
        data_in = 8'h00;
        tick(8);
        rst_n <= 1'b1;
        port_enable <= 1'b1;
        tick(1);
        #1 chk({write_collision_flag, mode_fault_flag, receive_overrun_flag, port_irq, transmit_buffer_empty}, 1);
        t_modes;
        t_tx;
        t_mode_fault_flag;
        t_rx;
        t_off;
        tally_and_finish;
    end
endmodule // spicsf_flags_test
